// [rtl/pioc_top.sv]
// process input-output controllers: contact input, grouped, timed and setpoint outputs
`timescale 1ns/1ps
module pioc_top #(
  parameter int unsigned MO_OP_CYC   = pioc_pkg::MO_OP_US * pioc_pkg::CLK_MHZ,
  parameter int unsigned MO_REC_CYC  = pioc_pkg::MO_REC_US * pioc_pkg::CLK_MHZ,
  parameter int unsigned MO_LONG_CYC = pioc_pkg::MO_LONG_US * pioc_pkg::CLK_MHZ,
  parameter int unsigned VO_OP_CYC   = pioc_pkg::VO_OP_US * pioc_pkg::CLK_MHZ,
  parameter int unsigned TO_HALF_CYC = pioc_pkg::CLK_MHZ * 1000000 / (2 * pioc_pkg::TO_OSC_HZ)
) (
  input  wire logic                                        clk_sys_i,
  input  wire logic                                        srst_i,
  input  wire logic [pioc_pkg::ADDR_W-1:0]                 addr_i,
  input  wire logic [pioc_pkg::DATA_W-1:0]                 wdata_i,
  input  wire logic                                        we_i,
  input  wire logic                                        re_i,
  output logic      [pioc_pkg::DATA_W-1:0]                 rdata_o,
  input  wire logic [pioc_pkg::DI_GROUPS-1:0][pioc_pkg::DI_GRP_W-1:0] di_pins_i,
  input  wire logic                                        di_valid_i,
  output logic                                             di_change_o,
  output logic      [pioc_pkg::GRP_IDX_W-1:0]              mo_group_o,
  output logic      [2:0]                                  mo_type_o,
  output logic      [pioc_pkg::MO_RLY_W-1:0]               mo_relays_o,
  output logic                                             mo_drive_o,
  output logic                                             mo_busy_o,
  input  wire logic                                        to_line_i,
  output logic      [pioc_pkg::TO_PT_W-1:0]                to_point_o,
  output logic                                             to_up_o,
  output logic                                             to_pulse_o,
  output logic                                             to_busy_o,
  output logic                                             to_alarm_o,
  output logic      [pioc_pkg::VO_ADDR_W-1:0]              vo_addr_o,
  output logic                                             vo_incr_o,
  output logic                                             vo_sign_o,
  output logic      [pioc_pkg::VO_VAL_W-1:0]               vo_mag_o,
  output logic                                             vo_drive_o
);

  typedef struct packed {
    logic [pioc_pkg::DI_GROUPS-1:0][pioc_pkg::DI_GRP_W-1:0] di_m1;
    logic [pioc_pkg::DI_GROUPS-1:0][pioc_pkg::DI_GRP_W-1:0] di_m2;
    logic [pioc_pkg::DI_GROUPS-1:0][pioc_pkg::DI_GRP_W-1:0] di_m3;
    logic [pioc_pkg::DI_GROUPS-1:0][pioc_pkg::DI_GRP_W-1:0] di_stb;
    logic [2:0]                                 vld_sh;
    logic                                       vld_stb;
    logic [2:0]                                 line_sh;
    logic                                       line_stb;
    logic [pioc_pkg::DI_GROUPS-1:0][2:0]        mo_type;
    logic [pioc_pkg::DATA_W-1:0]                rdata;
    logic [pioc_pkg::CTRL_W-1:0]                ctrl;
    logic                                       di_chg;
    logic                                       mo_err;
    logic                                       to_alm;
    logic                                       vo_err;
    pioc_pkg::pioc_phase_e                      mo_ph;
    logic [pioc_pkg::CNT_W-1:0]                 mo_cnt;
    logic [pioc_pkg::MO_HOLD_W-1:0]             mo_hold;
    logic [pioc_pkg::GRP_IDX_W-1:0]             mo_grp;
    logic [2:0]                                 mo_gt;
    logic [pioc_pkg::MO_RLY_W-1:0]              mo_rly;
    logic                                       to_busy;
    logic [pioc_pkg::TO_PT_W-1:0]               to_pt;
    logic                                       to_up;
    logic [pioc_pkg::TO_CNT_W-1:0]              to_left;
    logic                                       to_pulse;
    logic [pioc_pkg::CNT_W-1:0]                 to_div;
    logic                                       vo_busy;
    logic [pioc_pkg::CNT_W-1:0]                 vo_cnt;
    logic [pioc_pkg::VO_ADDR_W-1:0]             vo_addr;
    logic                                       vo_incr;
    logic [pioc_pkg::VO_VAL_W-1:0]              vo_val;
  } pioc_state_s;

  pioc_state_s q;
  pioc_state_s d;

  logic [pioc_pkg::GRP_IDX_W-1:0] idx;
  logic [pioc_pkg::GRP_IDX_W-1:0] cmd_grp;
  logic [2:0]                     cmd_gt;
  logic [pioc_pkg::CNT_W-1:0]     mo_len;
  logic                           tick;
  logic                           wr_stat;
  logic [pioc_pkg::ADDR_W-1:0]    vo_cap;
  logic [pioc_pkg::DI_GROUPS*pioc_pkg::DI_GRP_W-1:0] agree;

  // word index of a table address; used for both table reads and writes
  function automatic logic [pioc_pkg::GRP_IDX_W-1:0] pioc_word(input logic [pioc_pkg::ADDR_W-1:0] a);
    pioc_word = a[pioc_pkg::GRP_IDX_W+1:2];
  endfunction : pioc_word

  // groups past sixteen exist only with the expansion fitted
  function automatic logic pioc_fitted(input logic [pioc_pkg::GRP_IDX_W-1:0] g, input logic exp);
    pioc_fitted = exp || (g[pioc_pkg::GRP_IDX_W-1:pioc_pkg::GRP_IDX_W-2] == pioc_pkg::DI_STD_HI);
  endfunction : pioc_fitted

  // two-of-five relay code per decimal digit; non-decimal codes blank the digit
  function automatic logic [pioc_pkg::SEG_W-1:0] pioc_digit(input logic [pioc_pkg::DIGIT_W-1:0] v);
    case (v)
      4'h0:    pioc_digit = 5'h18;
      4'h1:    pioc_digit = 5'h03;
      4'h2:    pioc_digit = 5'h05;
      4'h3:    pioc_digit = 5'h06;
      4'h4:    pioc_digit = 5'h09;
      4'h5:    pioc_digit = 5'h0a;
      4'h6:    pioc_digit = 5'h0c;
      4'h7:    pioc_digit = 5'h11;
      4'h8:    pioc_digit = 5'h12;
      4'h9:    pioc_digit = 5'h14;
      default: pioc_digit = 5'h00;
    endcase
  endfunction : pioc_digit

  function automatic logic [pioc_pkg::MO_RLY_W-1:0] pioc_map(input logic [2:0] gt,
                                                           input logic [pioc_pkg::MO_DATA_W-1:0] v);
    pioc_map = '0;
    case (pioc_pkg::pioc_gtype_e'(gt))
      pioc_pkg::PIOC_GT_DIG:   pioc_map[pioc_pkg::MO_DATA_W-1:0] = v;
      pioc_pkg::PIOC_GT_DISP: begin
        for (int k = 0; k < pioc_pkg::DIGITS; k++) begin
          pioc_map[k*pioc_pkg::SEG_W +: pioc_pkg::SEG_W] = pioc_digit(v[k*pioc_pkg::DIGIT_W +: pioc_pkg::DIGIT_W]);
        end
      end
      pioc_pkg::PIOC_GT_ANA8:  pioc_map[pioc_pkg::MO_DATA_W-1:0] = v;
      pioc_pkg::PIOC_GT_ANA10: pioc_map[pioc_pkg::ANA10_W-1:0] = v[pioc_pkg::ANA10_W-1:0];
      default:                 pioc_map = '0;
    endcase
  endfunction : pioc_map

  always_comb begin
    d       = q;
    idx     = pioc_word(addr_i);
    cmd_grp = wdata_i[pioc_pkg::MO_GRP_LSB +: pioc_pkg::GRP_IDX_W];
    cmd_gt  = q.mo_type[cmd_grp];
    wr_stat = we_i && (addr_i == pioc_pkg::A_STAT);
    vo_cap  = pioc_pkg::VO_CAP_MIN << q.ctrl[pioc_pkg::CTL_VO_CAP +: 2];
    tick    = 1'b0;

    // contact inputs: three stages, a bit moves only when stages two and three agree
    d.di_m1   = di_pins_i;
    d.di_m2   = q.di_m1;
    d.di_m3   = q.di_m2;
    agree     = ~(q.di_m2 ^ q.di_m3);
    d.di_stb  = (agree & q.di_m2) | (~agree & q.di_stb);
    d.vld_sh  = {q.vld_sh[1:0], di_valid_i};
    d.vld_stb = (q.vld_sh[1] == q.vld_sh[2]) ? q.vld_sh[1] : q.vld_stb;
    d.line_sh = {q.line_sh[1:0], to_line_i};
    d.line_stb = (q.line_sh[1] == q.line_sh[2]) ? q.line_sh[1] : q.line_stb;

    // status flags: software clear first so a same-cycle event still sets
    if (wr_stat) begin
      d.di_chg = q.di_chg & ~wdata_i[pioc_pkg::ST_DI_CHG];
      d.mo_err = q.mo_err & ~wdata_i[pioc_pkg::ST_MO_ERR];
      d.to_alm = q.to_alm & ~wdata_i[pioc_pkg::ST_TO_ALM];
      d.vo_err = q.vo_err & ~wdata_i[pioc_pkg::ST_VO_ERR];
    end

    // change detection across fitted groups only
    for (int g = 0; g < pioc_pkg::DI_GROUPS; g++) begin
      if (q.ctrl[pioc_pkg::CTL_DI_CHG] && pioc_fitted(pioc_pkg::GRP_IDX_W'(g), q.ctrl[pioc_pkg::CTL_DI_EXP]) &&
          (d.di_stb[g] != q.di_stb[g])) begin
        d.di_chg = 1'b1;
      end
    end

    // plain registers and group type table
    if (we_i) begin
      if (addr_i == pioc_pkg::A_CTRL) begin
        d.ctrl = wdata_i[pioc_pkg::CTRL_W-1:0];
      end else if ((addr_i >= pioc_pkg::A_TYPE_BASE) && (addr_i < pioc_pkg::A_MO_CMD)) begin
        d.mo_type[idx] = wdata_i[2:0];
      end
    end

    // grouped outputs: own timing once the word is taken
    mo_len = q.ctrl[pioc_pkg::CTL_MO_TSEL] ?
             (q.ctrl[pioc_pkg::CTL_MO_LONG] ? pioc_pkg::CNT_W'(MO_LONG_CYC - 1) :
                                               pioc_pkg::CNT_W'(pioc_pkg::MO_SHORT_CYC - 1)) :
             pioc_pkg::CNT_W'(MO_OP_CYC - 1);
    case (q.mo_ph)
      pioc_pkg::PIOC_IDLE: begin
        // a word arriving while busy is dropped; software must wait for idle
        if (we_i && (addr_i == pioc_pkg::A_MO_CMD)) begin
          if (pioc_pkg::pioc_gtype_e'(cmd_gt) == pioc_pkg::PIOC_GT_NONE) begin
            d.mo_err = 1'b1;
          end else begin
            d.mo_hold = wdata_i[pioc_pkg::MO_HOLD_W-1:0];
            d.mo_grp  = cmd_grp;
            d.mo_gt   = cmd_gt;
            d.mo_rly  = pioc_map(cmd_gt, wdata_i[pioc_pkg::MO_DATA_W-1:0]);
            d.mo_cnt  = mo_len;
            d.mo_ph   = pioc_pkg::PIOC_OP;
          end
        end
      end
      pioc_pkg::PIOC_OP: begin
        if (q.mo_cnt == '0) begin
          d.mo_ph  = pioc_pkg::PIOC_REC;
          d.mo_cnt = pioc_pkg::CNT_W'(MO_REC_CYC - 1);
          d.mo_rly = '0;
        end else begin
          d.mo_cnt = q.mo_cnt - 1'b1;
        end
      end
      pioc_pkg::PIOC_REC: begin
        if (q.mo_cnt == '0) begin
          d.mo_ph = pioc_pkg::PIOC_IDLE;
        end else begin
          d.mo_cnt = q.mo_cnt - 1'b1;
        end
      end
      default: d.mo_ph = pioc_pkg::PIOC_IDLE;
    endcase

    // timed output pulse source
    if (q.to_div == '0) begin
      d.to_div = pioc_pkg::CNT_W'(TO_HALF_CYC - 1);
    end else begin
      d.to_div = q.to_div - 1'b1;
    end
    tick = q.ctrl[pioc_pkg::CTL_TO_OSC] ? (q.to_div == '0) : (d.line_stb && !q.line_stb);

    // timed output: one point only; a second point while active is refused
    if (we_i && (addr_i == pioc_pkg::A_TO_CMD)) begin
      if (q.to_busy) begin
        d.to_alm = 1'b1;
      end else if (wdata_i[pioc_pkg::TO_CNT_W-1:0] != '0) begin
        d.to_busy  = 1'b1;
        d.to_pt    = wdata_i[pioc_pkg::TO_PT_LSB +: pioc_pkg::TO_PT_W];
        d.to_up    = wdata_i[pioc_pkg::TO_DIR_BIT];
        d.to_left  = wdata_i[pioc_pkg::TO_CNT_W-1:0];
        d.to_pulse = 1'b0;
      end
    end else if (q.to_busy && tick) begin
      if (!q.to_pulse) begin
        d.to_pulse = 1'b1;
      end else begin
        d.to_pulse = 1'b0;
        d.to_left  = q.to_left - 1'b1;
        if (q.to_left == pioc_pkg::TO_CNT_W'(1)) begin
          d.to_busy = 1'b0;
        end
      end
    end

    // setpoint analog outputs
    if (we_i && (addr_i == pioc_pkg::A_VO_CMD) && !q.vo_busy) begin
      if ({1'b0, wdata_i[pioc_pkg::VO_ADDR_LSB +: pioc_pkg::VO_ADDR_W]} >= vo_cap) begin
        d.vo_err = 1'b1;
      end else begin
        d.vo_addr = wdata_i[pioc_pkg::VO_ADDR_LSB +: pioc_pkg::VO_ADDR_W];
        d.vo_incr = wdata_i[pioc_pkg::VO_MODE_BIT];
        d.vo_val  = wdata_i[pioc_pkg::VO_VAL_W-1:0];
        d.vo_busy = 1'b1;
        d.vo_cnt  = pioc_pkg::CNT_W'(VO_OP_CYC - 1);
      end
    end else if (q.vo_busy) begin
      if (q.vo_cnt == '0) begin
        d.vo_busy = 1'b0;
      end else begin
        d.vo_cnt = q.vo_cnt - 1'b1;
      end
    end

    // read data stands one cycle, zero otherwise
    d.rdata = '0;
    if (re_i) begin
      if (addr_i < pioc_pkg::A_TYPE_BASE) begin
        if (pioc_fitted(idx, q.ctrl[pioc_pkg::CTL_DI_EXP])) begin
          d.rdata = {8'h00, q.vld_stb, q.di_stb[idx]};
        end
      end else if (addr_i < pioc_pkg::A_MO_CMD) begin
        d.rdata = {29'h0000000, q.mo_type[idx]};
      end else if (addr_i == pioc_pkg::A_MO_CMD) begin
        d.rdata = {10'h000, q.mo_hold};
      end else if (addr_i == pioc_pkg::A_TO_CMD) begin
        d.rdata = {16'h0000, q.to_pt, q.to_up, q.to_left};
      end else if (addr_i == pioc_pkg::A_VO_CMD) begin
        d.rdata = {10'h000, q.vo_addr, q.vo_incr, q.vo_val};
      end else if (addr_i == pioc_pkg::A_CTRL) begin
        d.rdata = {25'h0000000, q.ctrl};
      end else if (addr_i == pioc_pkg::A_STAT) begin
        d.rdata = {24'h000000, q.vo_err, q.to_alm, q.mo_err, q.di_chg, 1'b0,
                   q.vo_busy, q.to_busy, (q.mo_ph != pioc_pkg::PIOC_IDLE)};
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata_o     = q.rdata;
  assign di_change_o = q.di_chg & q.ctrl[pioc_pkg::CTL_DI_CHG];
  assign mo_group_o  = q.mo_grp;
  assign mo_type_o   = q.mo_gt;
  assign mo_relays_o = q.mo_rly;
  assign mo_drive_o  = (q.mo_ph == pioc_pkg::PIOC_OP);
  assign mo_busy_o   = (q.mo_ph != pioc_pkg::PIOC_IDLE);
  assign to_point_o  = q.to_pt;
  assign to_up_o     = q.to_up;
  assign to_pulse_o  = q.to_pulse;
  assign to_busy_o   = q.to_busy;
  assign to_alarm_o  = q.to_alm;
  assign vo_addr_o   = q.vo_addr;
  assign vo_incr_o   = q.vo_incr;
  // incremental value is sign plus eleven-bit magnitude
  assign vo_sign_o   = q.vo_incr & q.vo_val[pioc_pkg::VO_VAL_W-1];
  assign vo_mag_o    = q.vo_incr ? {1'b0, q.vo_val[pioc_pkg::VO_VAL_W-2:0]} : q.vo_val;
  assign vo_drive_o  = q.vo_busy;

endmodule : pioc_top

// [rtl/pioc_pkg.sv]
// constants, types and register map of the process input-output controllers
package pioc_pkg;
  // clock and times, each time in its own unit
  localparam int unsigned CLK_MHZ      = 40;
  localparam int unsigned MO_OP_US     = 3500;
  localparam int unsigned MO_REC_US    = 500;
  localparam int unsigned MO_SHORT_US  = 40;
  localparam int unsigned MO_LONG_US   = 75000;
  localparam int unsigned VO_OP_US     = 5000;
  localparam int unsigned TO_OSC_HZ    = 1000;
  localparam int unsigned MO_SHORT_CYC = MO_SHORT_US * CLK_MHZ;

  // widths
  localparam int ADDR_W     = 10;
  localparam int DATA_W     = 32;
  localparam int CNT_W      = 23;
  localparam int DI_GRP_W   = 23;
  localparam int DI_GROUPS  = 64;
  localparam int GRP_IDX_W  = 6;
  localparam int MO_DATA_W  = 16;
  localparam int MO_RLY_W   = 20;
  localparam int MO_HOLD_W  = 22;
  localparam int DIGITS     = 4;
  localparam int DIGIT_W    = 4;
  localparam int SEG_W      = 5;
  localparam int ANA10_W    = 10;
  localparam int TO_PT_W    = 7;
  localparam int TO_CNT_W   = 8;
  localparam int VO_ADDR_W  = 9;
  localparam int VO_VAL_W   = 12;
  localparam int CTRL_W     = 7;

  // register byte addresses
  localparam logic [ADDR_W-1:0] A_DI_BASE   = 10'h000;
  localparam logic [ADDR_W-1:0] A_TYPE_BASE = 10'h100;
  localparam logic [ADDR_W-1:0] A_MO_CMD    = 10'h200;
  localparam logic [ADDR_W-1:0] A_TO_CMD    = 10'h204;
  localparam logic [ADDR_W-1:0] A_VO_CMD    = 10'h208;
  localparam logic [ADDR_W-1:0] A_CTRL      = 10'h20c;
  localparam logic [ADDR_W-1:0] A_STAT      = 10'h210;

  // command word fields
  localparam int MO_GRP_LSB  = 16;
  localparam int TO_DIR_BIT  = 8;
  localparam int TO_PT_LSB   = 9;
  localparam int VO_MODE_BIT = 12;
  localparam int VO_ADDR_LSB = 13;

  // control bits
  localparam int CTL_DI_EXP  = 0;
  localparam int CTL_DI_CHG  = 1;
  localparam int CTL_MO_TSEL = 2;
  localparam int CTL_MO_LONG = 3;
  localparam int CTL_TO_OSC  = 4;
  localparam int CTL_VO_CAP  = 5;

  // status bits
  localparam int ST_MO_BUSY = 0;
  localparam int ST_TO_BUSY = 1;
  localparam int ST_VO_BUSY = 2;
  localparam int ST_DI_CHG  = 4;
  localparam int ST_MO_ERR  = 5;
  localparam int ST_TO_ALM  = 6;
  localparam int ST_VO_ERR  = 7;

  localparam logic [1:0]  DI_STD_HI  = 2'h0;
  localparam logic [ADDR_W-1:0] VO_CAP_MIN = 10'h040;

  typedef enum logic [2:0] {PIOC_GT_NONE, PIOC_GT_DIG, PIOC_GT_DISP, PIOC_GT_ANA8, PIOC_GT_ANA10} pioc_gtype_e;
  typedef enum logic [1:0] {PIOC_IDLE, PIOC_OP, PIOC_REC} pioc_phase_e;
endpackage : pioc_pkg

// [tb/pioc_plant.sv]
// plant-side mains pulse source feeding the timed output controller
`timescale 1ns/1ps
module pioc_plant #(
  parameter int HALF = 6
) (
  input  wire logic clk_sys_i,
  output logic      line_o
);
  int cnt;
  initial begin
    line_o = 1'b0;
    cnt = 0;
  end
  // mains runs free, so ticks land at any phase of a command
  always @(posedge clk_sys_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) line_o <= ~line_o;
  end
endmodule : pioc_plant

// [tb/pioc_top_chk.sv]
// concurrent checks on the ports of the process input-output controllers
`timescale 1ns/1ps
module pioc_top_chk #(
  parameter int unsigned MO_OP_CYC   = pioc_pkg::MO_OP_US * pioc_pkg::CLK_MHZ,
  parameter int unsigned MO_REC_CYC  = pioc_pkg::MO_REC_US * pioc_pkg::CLK_MHZ,
  parameter int unsigned MO_LONG_CYC = pioc_pkg::MO_LONG_US * pioc_pkg::CLK_MHZ,
  parameter int unsigned VO_OP_CYC   = pioc_pkg::VO_OP_US * pioc_pkg::CLK_MHZ
) (
  input wire logic                          clk_sys_i,
  input wire logic                          srst_i,
  input wire logic [pioc_pkg::ADDR_W-1:0]   addr_i,
  input wire logic [pioc_pkg::DATA_W-1:0]   wdata_i,
  input wire logic                          we_i,
  input wire logic                          re_i,
  input wire logic [pioc_pkg::DATA_W-1:0]   rdata_o,
  input wire logic [pioc_pkg::GRP_IDX_W-1:0] mo_group_o,
  input wire logic [pioc_pkg::MO_RLY_W-1:0] mo_relays_o,
  input wire logic                          mo_drive_o,
  input wire logic                          mo_busy_o,
  input wire logic [pioc_pkg::TO_PT_W-1:0]  to_point_o,
  input wire logic                          to_pulse_o,
  input wire logic                          to_busy_o,
  input wire logic                          to_alarm_o,
  input wire logic [pioc_pkg::VO_ADDR_W-1:0] vo_addr_o,
  input wire logic                          vo_incr_o,
  input wire logic                          vo_sign_o,
  input wire logic [pioc_pkg::VO_VAL_W-1:0] vo_mag_o,
  input wire logic                          vo_drive_o
);
  int unsigned op_q;
  int unsigned rec_q;
  int unsigned vo_q;
  // phase lengths are too long for repetition, so count them here
  always_ff @(posedge clk_sys_i) begin
    op_q  <= (srst_i || !mo_drive_o) ? 0 : op_q + 1;
    rec_q <= (srst_i || !mo_busy_o || mo_drive_o) ? 0 : rec_q + 1;
    vo_q  <= (srst_i || !vo_drive_o) ? 0 : vo_q + 1;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  mo_start_a: assert property ($rose(mo_drive_o) |-> $past(we_i) && $past(addr_i) == pioc_pkg::A_MO_CMD
    && mo_group_o == $past(wdata_i[21:16])) else $error("grouped output started without its command");
  relay_idle_a: assert property (!mo_drive_o |-> mo_relays_o == '0)
    else $error("relays energised outside operate phase");
  op_len_a: assert property ($fell(mo_drive_o) |-> op_q inside {MO_OP_CYC, pioc_pkg::MO_SHORT_CYC, MO_LONG_CYC})
    else $error("operate phase length wrong");
  rec_len_a: assert property ($fell(mo_busy_o) |-> rec_q == MO_REC_CYC)
    else $error("recovery phase length wrong");
  to_start_a: assert property ($rose(to_busy_o) |-> $past(we_i) && $past(addr_i) == pioc_pkg::A_TO_CMD
    && $past(wdata_i[7:0]) != 8'h00) else $error("timed output started without a counted command");
  busy_alarm_a: assert property (to_busy_o && we_i && addr_i == pioc_pkg::A_TO_CMD |=> to_alarm_o
    && $stable(to_point_o)) else $error("second timed command not blocked");
  pulse_busy_a: assert property (to_pulse_o |-> to_busy_o)
    else $error("pulse outside timed operation");
  vo_start_a: assert property ($rose(vo_drive_o) |-> vo_addr_o == $past(wdata_i[21:13])
    && vo_incr_o == $past(wdata_i[12])) else $error("setpoint fields differ from command");
  vo_len_a: assert property ($fell(vo_drive_o) |-> vo_q == VO_OP_CYC)
    else $error("setpoint operation length wrong");
  vo_sign_a: assert property (vo_drive_o |-> (vo_incr_o ? !vo_mag_o[11] : !vo_sign_o))
    else $error("setpoint sign and magnitude decode wrong");
  rd_idle_a: assert property (!$past(re_i) |-> rdata_o == '0)
    else $error("read data outside read answer cycle");
  cover property ($rose(mo_drive_o));
  cover property ($rose(to_alarm_o));
  cover property ($rose(vo_drive_o) && vo_incr_o);
endmodule : pioc_top_chk

bind pioc_top pioc_top_chk #(.MO_OP_CYC(MO_OP_CYC), .MO_REC_CYC(MO_REC_CYC), .MO_LONG_CYC(MO_LONG_CYC),
  .VO_OP_CYC(VO_OP_CYC)) u_chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .mo_group_o(mo_group_o), .mo_relays_o(mo_relays_o),
  .mo_drive_o(mo_drive_o), .mo_busy_o(mo_busy_o), .to_point_o(to_point_o), .to_pulse_o(to_pulse_o),
  .to_busy_o(to_busy_o), .to_alarm_o(to_alarm_o), .vo_addr_o(vo_addr_o), .vo_incr_o(vo_incr_o),
  .vo_sign_o(vo_sign_o), .vo_mag_o(vo_mag_o), .vo_drive_o(vo_drive_o));

// [tb/tb_process_io_controllers.sv]
// self-checking bench for the process input-output controllers
`timescale 1ns/1ps
module tb_process_io_controllers;
  logic clk_sys_i = 1'b0;
  logic srst_i, we_i, re_i, di_valid_i, to_line_i;
  logic [9:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [pioc_pkg::DI_GROUPS-1:0][pioc_pkg::DI_GRP_W-1:0] di_pins_i;
  logic di_change_o, mo_drive_o, mo_busy_o, to_up_o, to_pulse_o, to_busy_o, to_alarm_o;
  logic vo_incr_o, vo_sign_o, vo_drive_o;
  logic [5:0] mo_group_o;
  logic [2:0] mo_type_o;
  logic [19:0] mo_relays_o;
  logic [6:0] to_point_o;
  logic [8:0] vo_addr_o;
  logic [11:0] vo_mag_o;
  int n_errors = 0;
  int cmp_count = 0;
  localparam logic [5:0] MG[5] = '{6'h02, 6'h03, 6'h04, 6'h06, 6'h3f};
  localparam logic [2:0] MT[5] = '{3'h2, 3'h1, 3'h4, 3'h3, 3'h1};
  localparam logic [15:0] MD[5] = '{16'h9350, 16'hbeef, 16'hffff, 16'h1234, 16'h00a5};
  localparam logic [19:0] MR[5] = '{20'ha1958, 20'h0beef, 20'h003ff, 20'h01234, 20'h000a5};

  pioc_top #(.MO_OP_CYC(20), .MO_REC_CYC(5), .MO_LONG_CYC(30), .VO_OP_CYC(10), .TO_HALF_CYC(4)) DUT (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .di_pins_i(di_pins_i), .di_valid_i(di_valid_i), .di_change_o(di_change_o),
    .mo_group_o(mo_group_o), .mo_type_o(mo_type_o), .mo_relays_o(mo_relays_o), .mo_drive_o(mo_drive_o),
    .mo_busy_o(mo_busy_o), .to_line_i(to_line_i), .to_point_o(to_point_o), .to_up_o(to_up_o),
    .to_pulse_o(to_pulse_o), .to_busy_o(to_busy_o), .to_alarm_o(to_alarm_o), .vo_addr_o(vo_addr_o),
    .vo_incr_o(vo_incr_o), .vo_sign_o(vo_sign_o), .vo_mag_o(vo_mag_o), .vo_drive_o(vo_drive_o));
  pioc_plant u_plant (.clk_sys_i(clk_sys_i), .line_o(to_line_i));

  always #12.5 clk_sys_i = ~clk_sys_i;

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_sys_i);
    we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_sys_i);
    re_i <= 1'b0;
    #1;
    cmp("rdata", e, rdata_o);
  endtask : rd
  function automatic logic sig(input int s);
    case (s)
      0: return mo_drive_o;
      1: return mo_busy_o;
      2: return vo_drive_o;
      default: return to_busy_o;
    endcase
  endfunction : sig
  // counts cycles while the chosen level stays high, bounded against hangs
  task automatic len(input int s, output int n);
    n = 0;
    while (sig(s) === 1'b1 && n < 5000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
  endtask : len
  task automatic wait_idle();
    int n;
    len(1, n);
    len(2, n);
    len(3, n);
  endtask : wait_idle
  task automatic pulses(output int n);
    int i;
    logic p;
    n = 0;
    p = 1'b0;
    for (i = 0; i < 5000 && to_busy_o === 1'b1; i++) begin
      if (to_pulse_o === 1'b1 && p === 1'b0) n++;
      p = to_pulse_o;
      @(posedge clk_sys_i);
      #1;
    end
  endtask : pulses

  task automatic t_di();
    rd(pioc_pkg::A_CTRL, 32'h0);
    rd(10'h3f0, 32'h0);
    @(posedge clk_sys_i);
    di_pins_i[1] <= 23'h5a5a5a;
    di_pins_i[20] <= 23'h123456;
    // group 2 goes high unread, then low again; a read must show only the present level
    di_pins_i[2] <= 23'h7fffff;
    repeat (6) @(posedge clk_sys_i);
    rd(10'h004, 32'h00da5a5a);
    rd(10'h050, 32'h0);
    wr(pioc_pkg::A_CTRL, 32'h3);
    rd(10'h050, 32'h00923456);
    @(posedge clk_sys_i);
    di_valid_i <= 1'b0;
    di_pins_i[1] <= 23'h000001;
    di_pins_i[2] <= 23'h000000;
    repeat (6) @(posedge clk_sys_i);
    #1;
    cmp("di_change", 1'b1, di_change_o);
    rd(10'h004, 32'h00000001);
    rd(10'h008, 32'h00000000);
    wr(pioc_pkg::A_STAT, 32'h10);
    @(posedge clk_sys_i);
    di_valid_i <= 1'b1;
    #1;
    cmp("di_change", 1'b0, di_change_o);
    $display("test contact inputs done");
  endtask : t_di

  task automatic t_mo();
    int i;
    int n;
    for (i = 0; i < 5; i++) begin
      wr(10'h100 + {2'b00, MG[i], 2'b00}, {29'h0, MT[i]});
      wr(pioc_pkg::A_MO_CMD, {10'h0, MG[i], MD[i]});
      #1;
      cmp("mo_group", MG[i], mo_group_o);
      cmp("mo_type", MT[i], mo_type_o);
      cmp("mo_relays", MR[i], mo_relays_o);
      len(0, n);
      cmp("mo_op", 20, n);
      len(1, n);
      cmp("mo_rec", 5, n);
    end
    wr(pioc_pkg::A_MO_CMD, 32'h0005ffff);
    #1;
    cmp("mo_busy", 1'b0, mo_busy_o);
    rd(pioc_pkg::A_STAT, 32'h20);
    wr(pioc_pkg::A_STAT, 32'h20);
    wr(pioc_pkg::A_MO_CMD, 32'h00031111);
    wr(pioc_pkg::A_MO_CMD, 32'h00020000);
    #1;
    cmp("mo_relays", 20'h01111, mo_relays_o);
    wait_idle();
    wr(pioc_pkg::A_CTRL, 32'h4);
    wr(pioc_pkg::A_MO_CMD, 32'h00030001);
    #1;
    len(0, n);
    cmp("mo_op", 1600, n);
    wait_idle();
    wr(pioc_pkg::A_CTRL, 32'hc);
    wr(pioc_pkg::A_MO_CMD, 32'h00030001);
    #1;
    len(0, n);
    cmp("mo_op", 30, n);
    wait_idle();
    $display("test grouped outputs done");
  endtask : t_mo

  task automatic t_to();
    int n;
    wr(pioc_pkg::A_CTRL, 32'h10);
    wr(pioc_pkg::A_TO_CMD, 32'h00000b02);
    #1;
    cmp("to_busy", 1'b1, to_busy_o);
    cmp("to_up", 1'b1, to_up_o);
    wr(pioc_pkg::A_TO_CMD, 32'h00000c01);
    #1;
    cmp("to_alarm", 1'b1, to_alarm_o);
    cmp("to_point", 7'h05, to_point_o);
    pulses(n);
    cmp("to_pulses", 2, n);
    wr(pioc_pkg::A_CTRL, 32'h0);
    wr(pioc_pkg::A_TO_CMD, 32'h0000fe03);
    #1;
    cmp("to_point", 7'h7f, to_point_o);
    cmp("to_up", 1'b0, to_up_o);
    pulses(n);
    cmp("to_pulses", 3, n);
    wr(pioc_pkg::A_TO_CMD, 32'h0000fe00);
    #1;
    cmp("to_busy", 1'b0, to_busy_o);
    $display("test timed outputs done");
  endtask : t_to

  task automatic t_vo();
    int n;
    wr(pioc_pkg::A_STAT, 32'hf0);
    wr(pioc_pkg::A_VO_CMD, 32'h0007f805);
    #1;
    cmp("vo_addr", 9'h03f, vo_addr_o);
    cmp("vo_incr", 1'b1, vo_incr_o);
    cmp("vo_sign", 1'b1, vo_sign_o);
    cmp("vo_mag", 12'h005, vo_mag_o);
    len(2, n);
    cmp("vo_op", 10, n);
    wr(pioc_pkg::A_VO_CMD, 32'h00080000);
    #1;
    cmp("vo_drive", 1'b0, vo_drive_o);
    rd(pioc_pkg::A_STAT, 32'h80);
    wr(pioc_pkg::A_CTRL, 32'h60);
    wr(pioc_pkg::A_VO_CMD, 32'h003fefff);
    #1;
    cmp("vo_addr", 9'h1ff, vo_addr_o);
    cmp("vo_incr", 1'b0, vo_incr_o);
    cmp("vo_sign", 1'b0, vo_sign_o);
    cmp("vo_mag", 12'hfff, vo_mag_o);
    wait_idle();
    $display("test setpoint outputs done");
  endtask : t_vo

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial begin
    srst_i = 1'b1;
    we_i = 1'b0;
    re_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    di_pins_i = '0;
    di_valid_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_di();
    t_mo();
    t_to();
    t_vo();
    summarize();
  end
  // whole run needs a few thousand cycles; allow ample margin
  initial begin
    #(25 * 20000);
    n_errors++;
    summarize();
  end
endmodule : tb_process_io_controllers
